/* meter_cfg_pkg.sv */
package meter_cfg_pkg;
    localparam int          ADDR_W            = 6;
    localparam int          CMD_W             = 8;
    localparam int          CFG_W             = 16;
    localparam int          CMD_DIR_BIT       = 7;
    localparam int          CMD_UNUSED_BIT    = 6;
    localparam logic [5:0]  OPCFG_ADDR        = 6'h09;
    localparam int          HPF_BYP_BIT       = 0;
    localparam int          LPF_BYP_BIT       = 1;
    localparam int          PULSE_OFF_BIT     = 2;
    localparam int          DIP_OFF_BIT       = 3;
    localparam int          SUSPEND_BIT       = 4;
    localparam int          TEMP_START_BIT    = 5;
    localparam int          SOFT_RST_BIT      = 6;
    localparam int          CYCLE_ACC_BIT     = 7;
    localparam int          CH1_SHORT_BIT     = 8;
    localparam int          CH2_SHORT_BIT     = 9;
    localparam int          SWAP_BIT          = 10;
    localparam int          RATE_LO_BIT       = 11;
    localparam int          SRC_LO_BIT        = 13;
    localparam int          POS_ONLY_BIT      = 15;
    localparam logic [15:0] OPCFG_RESET       = 16'h000C;
    localparam int          STATUS_RESET_BIT  = 6;
    localparam int          CLK_MHZ           = 100;
    localparam int          SOFT_RST_HOLD_NS  = 18000;
    localparam int          SOFT_RST_CYCLES   = (SOFT_RST_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam logic [1:0]  SRC_POWER         = 2'h0;
    localparam logic [1:0]  SRC_RESERVED      = 2'h1;
    localparam logic [1:0]  SRC_CH1           = 2'h2;
    localparam logic [1:0]  SRC_CH2           = 2'h3;
    localparam int          RATE_DIV_BASE_LOG = 7;
    localparam int          RATE_CNT_W        = 10;
endpackage : meter_cfg_pkg

/* wave_rate_divider.sv */
`timescale 1ns/1ps
module wave_rate_divider #(
    parameter int CNT_W = meter_cfg_pkg::RATE_CNT_W
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       clear_i,
    input  wire logic [1:0] rate_sel_i,
    output logic            tick_o
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             tick;
    } div_s;

    div_s st_q;
    div_s st_d;
    logic [CNT_W-1:0] last_w;

    // Terminal count is divisor minus one: 127, 255, 511 or 1023
    assign last_w = CNT_W'((32'h0000_0001 << (meter_cfg_pkg::RATE_DIV_BASE_LOG + 32'(rate_sel_i))) - 32'h0000_0001);

    always_comb begin
        st_d      = st_q;
        st_d.tick = 1'b0;
        if (clear_i || st_q.cnt >= last_w) begin
            st_d.cnt  = '0;
            st_d.tick = !clear_i;
        end else begin
            st_d.cnt = st_q.cnt + CNT_W'(1);
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick_o = st_q.tick;
endmodule : wave_rate_divider

/* meter_command_and_mode_regs.sv */
`timescale 1ns/1ps
module meter_command_and_mode_regs #(
    parameter int SOFT_RST_CYCLES = meter_cfg_pkg::SOFT_RST_CYCLES
) (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        byte_valid_i,
    input  wire logic [7:0]  byte_data_i,
    input  wire logic        word_valid_i,
    input  wire logic [15:0] word_wdata_i,
    input  wire logic        temp_done_i,
    input  wire logic        reset_flag_clear_i,
    output logic             xfer_pending_o,
    output logic             xfer_write_o,
    output logic [5:0]       xfer_addr_o,
    output logic             reg_wr_o,
    output logic             reg_rd_o,
    output logic [15:0]      rd_data_o,
    output logic             rd_data_valid_o,
    output logic             highpass_bypass_o,
    output logic             power_lowpass_bypass_o,
    output logic             pulse_output_off_o,
    output logic             dip_detect_off_o,
    output logic             converter_suspend_o,
    output logic             temperature_start_o,
    output logic             line_cycle_accumulate_o,
    output logic             channel1_short_o,
    output logic             channel2_short_o,
    output logic             input_swap_o,
    output logic [1:0]       waveform_rate_select_o,
    output logic [1:0]       waveform_source_select_o,
    output logic             positive_only_accumulate_o,
    output logic             waveform_tick_o,
    output logic             soft_reset_active_o,
    output logic             reset_done_flag_o,
    output logic             reset_flag_irq_enable_o
);
    typedef enum logic [1:0] {
        ST_WAIT_CMD  = 2'b00,
        ST_WAIT_DATA = 2'b01,
        ST_SOFT_RST  = 2'b10
    } phase_e;

    localparam int RST_CNT_W = $clog2(SOFT_RST_CYCLES + 1);

    typedef struct packed {
        phase_e                 phase;
        logic                   dir_write;
        logic [5:0]             addr;
        logic [15:0]            cfg;
        logic [RST_CNT_W-1:0]   rst_cnt;
        logic                   reset_done;
        logic                   reg_wr;
        logic                   reg_rd;
        logic [15:0]            rd_data;
        logic                   rd_valid;
        logic                   tick;
        logic                   pending;
        logic                   soft_active;
        logic                   irq_en;
    } regs_s;

    regs_s st_q;
    regs_s st_d;
    logic  tick_w;

    wave_rate_divider #(
        .CNT_W (meter_cfg_pkg::RATE_CNT_W)
    ) u_rate (
        .sys_clk_i  (sys_clk_i),
        .rst_n_i    (rst_n_i),
        .clear_i    (st_q.phase == ST_SOFT_RST),
        .rate_sel_i (st_q.cfg[meter_cfg_pkg::RATE_LO_BIT +: 2]),
        .tick_o     (tick_w)
    );

    always_comb begin
        st_d          = st_q;
        st_d.reg_wr   = 1'b0;
        st_d.reg_rd   = 1'b0;
        st_d.rd_valid = 1'b0;
        st_d.tick     = tick_w && (st_q.phase != ST_SOFT_RST);

        // Self-clear on completion; a later host write may set it again
        if (temp_done_i) begin
            st_d.cfg[meter_cfg_pkg::TEMP_START_BIT] = 1'b0;
        end
        // Hardware setting the flag beats a clear in the same cycle
        if (reset_flag_clear_i) begin
            st_d.reset_done = 1'b0;
        end

        unique case (st_q.phase)
            ST_WAIT_CMD: begin
                // Bytes here are always command bytes; nothing reads them back
                if (byte_valid_i) begin
                    st_d.addr      = byte_data_i[meter_cfg_pkg::ADDR_W-1:0];
                    st_d.dir_write = byte_data_i[meter_cfg_pkg::CMD_DIR_BIT];
                    st_d.phase     = ST_WAIT_DATA;
                end
            end
            ST_WAIT_DATA: begin
                if (st_q.dir_write && word_valid_i) begin
                    st_d.reg_wr = 1'b1;
                    st_d.phase  = ST_WAIT_CMD;
                    if (st_q.addr == meter_cfg_pkg::OPCFG_ADDR) begin
                        st_d.cfg = word_wdata_i;
                        if (word_wdata_i[meter_cfg_pkg::SOFT_RST_BIT]) begin
                            st_d.phase   = ST_SOFT_RST;
                            st_d.rst_cnt = '0;
                        end
                    end
                end else if (!st_q.dir_write) begin
                    // Read launched at once; word_valid is not looked at for a read
                    st_d.reg_rd   = 1'b1;
                    st_d.rd_valid = 1'b1;
                    st_d.rd_data  = (st_q.addr == meter_cfg_pkg::OPCFG_ADDR) ? st_q.cfg : 16'h0000;
                    st_d.phase    = ST_WAIT_CMD;
                end
            end
            ST_SOFT_RST: begin
                // Host traffic ignored during the hold; config back to defaults
                st_d.cfg = meter_cfg_pkg::OPCFG_RESET;
                if (st_q.rst_cnt >= RST_CNT_W'(SOFT_RST_CYCLES - 1)) begin
                    st_d.phase      = ST_WAIT_CMD;
                    st_d.reset_done = 1'b1;
                end else begin
                    st_d.rst_cnt = st_q.rst_cnt + RST_CNT_W'(1);
                end
            end
        endcase

        // Phase decodes kept in flops so the status outputs never glitch
        st_d.pending     = st_d.phase == ST_WAIT_DATA;
        st_d.soft_active = st_d.phase == ST_SOFT_RST;
        st_d.irq_en      = 1'b0;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q            <= '0;
            st_q.phase      <= ST_WAIT_CMD;
            st_q.cfg        <= meter_cfg_pkg::OPCFG_RESET;
            st_q.reset_done <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign xfer_pending_o             = st_q.pending;
    assign xfer_write_o               = st_q.dir_write;
    assign xfer_addr_o                = st_q.addr;
    assign reg_wr_o                   = st_q.reg_wr;
    assign reg_rd_o                   = st_q.reg_rd;
    assign rd_data_o                  = st_q.rd_data;
    assign rd_data_valid_o            = st_q.rd_valid;
    assign highpass_bypass_o          = st_q.cfg[meter_cfg_pkg::HPF_BYP_BIT];
    assign power_lowpass_bypass_o     = st_q.cfg[meter_cfg_pkg::LPF_BYP_BIT];
    assign pulse_output_off_o         = st_q.cfg[meter_cfg_pkg::PULSE_OFF_BIT];
    assign dip_detect_off_o           = st_q.cfg[meter_cfg_pkg::DIP_OFF_BIT];
    assign converter_suspend_o        = st_q.cfg[meter_cfg_pkg::SUSPEND_BIT];
    assign temperature_start_o        = st_q.cfg[meter_cfg_pkg::TEMP_START_BIT];
    assign line_cycle_accumulate_o    = st_q.cfg[meter_cfg_pkg::CYCLE_ACC_BIT];
    assign channel1_short_o           = st_q.cfg[meter_cfg_pkg::CH1_SHORT_BIT];
    assign channel2_short_o           = st_q.cfg[meter_cfg_pkg::CH2_SHORT_BIT];
    assign input_swap_o               = st_q.cfg[meter_cfg_pkg::SWAP_BIT];
    assign waveform_rate_select_o     = st_q.cfg[meter_cfg_pkg::RATE_LO_BIT +: 2];
    assign waveform_source_select_o   = st_q.cfg[meter_cfg_pkg::SRC_LO_BIT +: 2];
    assign positive_only_accumulate_o = st_q.cfg[meter_cfg_pkg::POS_ONLY_BIT];
    assign waveform_tick_o            = st_q.tick;
    assign soft_reset_active_o        = st_q.soft_active;
    // Reset-complete flag can never be enabled onto the interrupt
    assign reset_flag_irq_enable_o    = st_q.irq_en;
    assign reset_done_flag_o          = st_q.reset_done;
endmodule : meter_command_and_mode_regs

/* meter_cmd_checker_assertions.sv */
`timescale 1ns/1ps
module meter_cmd_checker (
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic        byte_valid_i,
    input wire logic [7:0]  byte_data_i,
    input wire logic        word_valid_i,
    input wire logic [15:0] word_wdata_i,
    input wire logic        temp_done_i,
    input wire logic        xfer_pending_o,
    input wire logic        xfer_write_o,
    input wire logic [5:0]  xfer_addr_o,
    input wire logic        reg_wr_o,
    input wire logic        reg_rd_o,
    input wire logic        rd_data_valid_o,
    input wire logic        soft_reset_active_o,
    input wire logic        reset_done_flag_o,
    input wire logic        reset_flag_irq_enable_o,
    input wire logic        temperature_start_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_addr_take: assert property (byte_valid_i && !xfer_pending_o && !soft_reset_active_o |=>
        xfer_pending_o && xfer_addr_o == $past(byte_data_i[5:0])) else $error("command address not taken");
    a_dir_take: assert property (byte_valid_i && !xfer_pending_o && !soft_reset_active_o |=>
        xfer_write_o == $past(byte_data_i[7])) else $error("command direction not taken");
    a_read_answer: assert property (xfer_pending_o && !xfer_write_o |=>
        rd_data_valid_o && reg_rd_o && !xfer_pending_o) else $error("read not answered");
    a_write_answer: assert property (xfer_pending_o && xfer_write_o && word_valid_i |=>
        reg_wr_o && !xfer_pending_o) else $error("write not answered");
    a_temp_write: assert property (xfer_pending_o && xfer_write_o && word_valid_i && xfer_addr_o == 6'h09
        && !word_wdata_i[6] |=> temperature_start_o == $past(word_wdata_i[5])) else $error("start bit not written");
    a_temp_clear: assert property (temperature_start_o && temp_done_i && !word_valid_i |=>
        !temperature_start_o) else $error("start bit not cleared");
    a_soft_end: assert property ($fell(soft_reset_active_o) |-> ##[0:1] reset_done_flag_o)
        else $error("reset flag not set");
    a_soft_refuse: assert property (soft_reset_active_o |-> !xfer_pending_o)
        else $error("command taken during soft reset");
    a_irq_off: assert property (reset_flag_irq_enable_o == 1'b0)
        else $error("reset flag may raise interrupt");
endmodule : meter_cmd_checker
bind meter_command_and_mode_regs meter_cmd_checker meter_cmd_checker_i (.*);

/* meter_host_model.sv */
`timescale 1ns/1ps
module meter_host_model (
    input  wire logic        sys_clk_i,
    input  wire logic        busy_i,
    input  wire logic        ack_i,
    input  wire logic [15:0] rd_data_i,
    output logic             byte_valid_o,
    output logic [7:0]       byte_data_o,
    output logic             word_valid_o,
    output logic [15:0]      word_wdata_o
);
    // Host-side quiet time after a soft reset, kept by the host itself
    time quiet_until = 0;
    initial begin
        byte_valid_o = 1'b0;
        byte_data_o  = 8'h00;
        word_valid_o = 1'b0;
        word_wdata_o = 16'h0000;
    end
    task automatic xfer(input logic wr, input logic [5:0] adr, input logic [15:0] d,
                        output logic ack, output logic [15:0] q);
        while (busy_i || $time < quiet_until) begin
            @(posedge sys_clk_i);
            #1;
        end
        @(posedge sys_clk_i);
        byte_valid_o <= 1'b1;
        byte_data_o  <= {wr, 1'b0, adr};
        @(posedge sys_clk_i);
        byte_valid_o <= 1'b0;
        byte_data_o  <= ~byte_data_o;
        word_valid_o <= wr;
        word_wdata_o <= d;
        @(posedge sys_clk_i);
        // Released data lines flip so stale values never look valid
        word_valid_o <= 1'b0;
        word_wdata_o <= ~d;
        #1;
        ack = ack_i;
        q   = rd_data_i;
        if (wr && adr == meter_cfg_pkg::OPCFG_ADDR && d[meter_cfg_pkg::SOFT_RST_BIT]) begin
            quiet_until = $time + meter_cfg_pkg::SOFT_RST_HOLD_NS;
        end
    endtask : xfer
endmodule : meter_host_model

/* meter_command_and_mode_regs_tb.sv */
`timescale 1ns/1ps
module meter_command_and_mode_regs_tb;
    logic sys_clk_i, rst_n_i, byte_valid_i, word_valid_i, temp_done_i, reset_flag_clear_i, ack;
    logic xfer_pending_o, xfer_write_o, reg_wr_o, reg_rd_o, rd_data_valid_o, highpass_bypass_o;
    logic power_lowpass_bypass_o, pulse_output_off_o, dip_detect_off_o, converter_suspend_o;
    logic temperature_start_o, line_cycle_accumulate_o, channel1_short_o, channel2_short_o;
    logic input_swap_o, positive_only_accumulate_o, waveform_tick_o, soft_reset_active_o;
    logic reset_done_flag_o, reset_flag_irq_enable_o;
    logic [1:0] waveform_rate_select_o, waveform_source_select_o;
    logic [5:0] xfer_addr_o;
    logic [7:0] byte_data_i;
    logic [15:0] word_wdata_i, rd_data_o, q;
    int errors, n_checks, n;
    meter_command_and_mode_regs meter_command_and_mode_regs_i (.*);
    meter_host_model meter_host_model_i (.sys_clk_i, .busy_i(soft_reset_active_o),
        .ack_i(reg_wr_o | rd_data_valid_o), .rd_data_i(rd_data_o), .byte_valid_o(byte_valid_i),
        .byte_data_o(byte_data_i), .word_valid_o(word_valid_i), .word_wdata_o(word_wdata_i));
    function automatic logic [15:0] cfg_out();
        return {positive_only_accumulate_o, waveform_source_select_o, waveform_rate_select_o, input_swap_o,
            channel2_short_o, channel1_short_o, line_cycle_accumulate_o, 1'b0, temperature_start_o,
            converter_suspend_o, dip_detect_off_o, pulse_output_off_o, power_lowpass_bypass_o, highpass_bypass_o};
    endfunction : cfg_out
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : conclude
    task automatic xfer(input logic wr, input logic [5:0] adr, input logic [15:0] d, input logic [15:0] exp);
        meter_host_model_i.xfer(wr, adr, d, ack, q);
        check("handshake", {15'h0000, ack}, 16'h0001);
        if (!wr) check("read data", q, exp);
    endtask : xfer
    task automatic t_fields();
        logic [15:0] vals[5] = '{16'h0000, 16'hAAA5, 16'h5518, 16'h0003, 16'hFFBF};
        xfer(1'b0, 6'h09, 16'h0000, 16'h000C);
        foreach (vals[i]) begin
            xfer(1'b1, 6'h09, vals[i], 16'h0000);
            check("config ports", cfg_out(), vals[i]);
            xfer(1'b0, 6'h09, 16'h0000, vals[i]);
        end
        xfer(1'b1, 6'h0A, 16'h0000, 16'h0000);
        check("other address", cfg_out(), 16'hFFBF);
        @(posedge sys_clk_i);
        temp_done_i <= 1'b1;
        @(posedge sys_clk_i);
        temp_done_i <= 1'b0;
        #1;
        check("temp start", {15'h0000, temperature_start_o}, 16'h0000);
    endtask : t_fields
    task automatic t_soft();
        @(posedge sys_clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        #1;
        check("midrun defaults", cfg_out(), 16'h000C);
        check("midrun flag", {15'h0000, reset_done_flag_o}, 16'h0001);
        @(posedge sys_clk_i);
        reset_flag_clear_i <= 1'b1;
        @(posedge sys_clk_i);
        reset_flag_clear_i <= 1'b0;
        @(posedge sys_clk_i);
        #1;
        check("flag cleared", {15'h0000, reset_done_flag_o}, 16'h0000);
        xfer(1'b1, 6'h09, 16'h0040, 16'h0000);
        n = 0;
        while (soft_reset_active_o) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        check("hold long", 16'(n), 16'(meter_cfg_pkg::SOFT_RST_CYCLES));
        @(posedge sys_clk_i);
        #1;
        check("soft defaults", cfg_out(), 16'h000C);
        check("reset flag", {15'h0000, reset_done_flag_o}, 16'h0001);
    endtask : t_soft
    task automatic t_rate();
        for (int c = 0; c < 4; c++) begin
            xfer(1'b1, 6'h09, 16'(c) << 11, 16'h0000);
            do begin @(posedge sys_clk_i); #1; end while (!waveform_tick_o);
            n = 0;
            do begin @(posedge sys_clk_i); #1; n++; end while (!waveform_tick_o);
            check("tick period", 16'(n), 16'h0080 << c);
        end
    endtask : t_rate
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        errors++;
        conclude();
    end
    initial begin
        {rst_n_i, temp_done_i, reset_flag_clear_i} = 3'h0;
        repeat (20) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        #1;
        check("irq enable", {15'h0000, reset_flag_irq_enable_o}, 16'h0000);
        check("hw reset flag", {15'h0000, reset_done_flag_o}, 16'h0001);
        t_fields();
        t_soft();
        t_rate();
        conclude();
    end
endmodule : meter_command_and_mode_regs_tb
